// ==== rtl/ccsp_pkg.sv ====
// Purpose: Constants, enumerations and carriers of the segment parser
// Assumes: Multi-byte fields arrive most significant byte first
// Notes:   Registers sit on word-aligned APB byte addresses
package ccsp_pkg;
    localparam logic [7:0]  MARK_PREFIX = 8'hFF;
    localparam logic [15:0] COLL_MARKER = 16'hFF75;
    localparam logic [15:0] MDEF_MARKER = 16'hFF74;
    localparam logic [31:0] MIN_LEN     = 32'h0000_0003;
    localparam logic [31:0] LEN_BYTES   = 32'h0000_0004;

    localparam int STY_IDX_LSB  = 0;
    localparam int STY_TYPE_LSB = 4;
    localparam int STY_FMT_LSB  = 6;
    localparam int KIND_WAVE_BIT = 1;
    localparam int KIND_HP_BIT   = 0;
    localparam int CNT_W16_BIT  = 14;
    localparam int CNT_RSV_BIT  = 15;
    localparam int ASG_T_LSB    = 0;
    localparam int ASG_O_LSB    = 4;
    localparam int IDX_BITS     = 14;

    localparam int N_ERR     = 9;
    localparam int ERR_LEN   = 0;
    localparam int ERR_SIZE  = 1;
    localparam int ERR_EXTRA = 2;
    localparam int ERR_TILE2 = 3;
    localparam int ERR_DUP   = 4;
    localparam int ERR_WEQ   = 5;
    localparam int ERR_RANGE = 6;
    localparam int ERR_STYLE = 7;
    localparam int ERR_REF   = 8;

    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_SEG    = 12'h008;
    localparam logic [11:0] REG_STYLE  = 12'h00C;
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          CTRL_CLR_BIT = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    localparam logic [31:0] CTRL_MASK  = 32'h0000_0001;

    typedef enum logic [1:0] {
        MT_DECOR_XFORM, MT_DEPEND_XFORM, MT_DECOR_OFS, MT_DEPEND_OFS
    } ccsp_mtype_t;

    typedef enum logic [1:0] {
        EF_INT8, EF_INT16, EF_FLT32, EF_FLT64
    } ccsp_efmt_t;

    typedef enum logic [3:0] {
        S_HUNT, S_MARK, S_LEN, S_IDX, S_KIND, S_NIN, S_CIN,
        S_NOUT, S_COUT, S_ASG, S_STYLE, S_SKIP
    } ccsp_state_t;

    typedef struct packed {
        logic        valid;
        ccsp_efmt_t  fmt;
        ccsp_mtype_t mtype;
        logic [3:0]  idx;
    } ccsp_style_t;

    typedef struct packed {
        logic        valid;
        logic        wave;
        logic        hp_first;
        logic [13:0] n_in;
        logic        in_w16;
        logic [13:0] n_out;
        logic        out_w16;
        logic [3:0]  t_idx;
        logic [3:0]  o_idx;
        logic        t_tile;
        logic        o_tile;
    } ccsp_coll_t;

    typedef struct packed {
        logic        valid;
        logic        is_out;
        logic [13:0] idx;
    } ccsp_comp_t;

    typedef struct packed {
        logic        valid;
        logic        tile;
        logic        own;
        logic        ref_ok;
        logic [7:0]  idx;
        logic [7:0]  apply_idx;
        logic [15:0] q;
    } ccsp_seg_t;
endpackage

// ==== rtl/ccsp_parser.sv ====
// Purpose: Header segment parser for component collections and styles
// Assumes: Byte source and control pulses run on clk_sys
// Notes:   Output events pulse one cycle after the byte that ends them
`timescale 1ns/100ps
`default_nettype none

module ccsp_parser (
    input  wire logic               clk_sys,
    input  wire logic               rst,
    input  wire logic               in_valid,
    input  wire logic [7:0]         in_data,
    output logic                    in_ready,
    input  wire logic               in_tile_hdr,
    input  wire logic               tile_start,
    output ccsp_pkg::ccsp_style_t   style_out,
    output ccsp_pkg::ccsp_coll_t    coll_out,
    output ccsp_pkg::ccsp_comp_t    comp_out,
    output ccsp_pkg::ccsp_seg_t     seg_out,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr
);
    import ccsp_pkg::*;

    typedef struct packed {
        ccsp_state_t   st;
        logic          is_coll;
        logic [1:0]    bcnt;
        logic [31:0]   len;
        logic [31:0]   rem;
        logic [7:0]    hi;
        logic [13:0]   cnt;
        logic          w16;
        logic          tile;
        logic [7:0]    seg_idx;
        logic [15:0]   q;
        logic [255:0]  main_map;
        logic [63:0]   tile_mdef;
        logic          tile_seen;
        logic [N_ERR-1:0] err;
        logic [31:0]   ctrl;
        logic          in_ready;
        ccsp_style_t   style_out;
        ccsp_coll_t    coll_out;
        ccsp_comp_t    comp_out;
        ccsp_seg_t     seg_out;
        logic [31:0]   prdata;
        logic          pready;
        logic          pslverr;
        logic [16383:0] seen;
    } ccsp_regs_t;

    ccsp_regs_t       r;
    ccsp_regs_t       n;
    logic             take;
    logic             last;
    logic             mid;
    logic             idx_done;
    logic             fin;
    logic             acc;
    logic             commit;
    logic             mapped;
    logic [31:0]      rd;
    logic [31:0]      len_full;
    logic [15:0]      fld;
    logic [13:0]      ix;
    logic [N_ERR-1:0] set;
    logic [N_ERR-1:0] clr;

    function automatic logic cnt_w16(input logic [15:0] f);
        return f[CNT_W16_BIT];
    endfunction

    assign take     = in_valid & r.in_ready;
    assign last     = (r.rem == 32'h0000_0001);
    assign mid      = r.st inside {S_KIND, S_NIN, S_CIN, S_NOUT, S_COUT};
    assign len_full = {r.len[23:0], in_data};
    assign fld      = {r.hi, in_data};
    // 8-bit indices take the byte alone; no held high byte
    assign ix       = r.w16 ? fld[IDX_BITS-1:0] : {6'h00, in_data};
    assign idx_done = !r.w16 || r.bcnt[0];
    assign acc      = psel & penable;
    assign commit   = acc & r.pready;

    always_comb begin
        n = r;
        set = '0;
        clr = '0;
        fin = 1'b0;
        mapped = 1'b1;
        n.style_out.valid = 1'b0;
        n.coll_out.valid  = 1'b0;
        n.comp_out.valid  = 1'b0;
        n.seg_out.valid   = 1'b0;

        unique case (paddr)
            REG_CTRL:   rd = r.ctrl;
            REG_STATUS: rd = {15'h0000, r.main_map[0], 7'h00, r.err};
            REG_SEG:    rd = {r.seg_out.q, r.seg_out.ref_ok, r.seg_out.own,
                              r.seg_out.tile, 5'h00, r.seg_out.idx};
            REG_STYLE:  rd = {24'h000000, r.style_out.fmt,
                              r.style_out.mtype, r.style_out.idx};
            default: begin
                rd = 32'h0000_0000;
                mapped = 1'b0;
            end
        endcase
        // One wait state: pready rises on the first access edge
        if (acc && !r.pready) begin
            n.pready  = 1'b1;
            n.pslverr = !mapped;
            n.prdata  = rd;
        end else begin
            n.pready  = 1'b0;
            n.pslverr = 1'b0;
        end
        if (commit && pwrite && paddr == REG_CTRL) begin
            n.ctrl = pwdata & CTRL_MASK;
            if (pwdata[CTRL_CLR_BIT]) begin
                n.main_map = '0;
            end
        end
        if (commit && pwrite && paddr == REG_STATUS) begin
            clr = pwdata[N_ERR-1:0];
        end
        // Cleared first so a segment in this very cycle still counts
        if (tile_start) begin
            n.tile_mdef = '0;
            n.tile_seen = 1'b0;
        end

        if (take) begin
            if (!(r.st inside {S_HUNT, S_MARK, S_LEN})) begin
                n.rem = r.rem - 32'h0000_0001;
            end
            unique case (r.st)
                S_HUNT: begin
                    if (in_data == MARK_PREFIX) begin
                        n.st = S_MARK;
                    end
                end
                S_MARK: begin
                    n.bcnt = 2'd0;
                    if ({MARK_PREFIX, in_data} == COLL_MARKER) begin
                        n.is_coll = 1'b1;
                        n.st = S_LEN;
                    end else if ({MARK_PREFIX, in_data} == MDEF_MARKER) begin
                        n.is_coll = 1'b0;
                        n.st = S_LEN;
                    end else if (in_data != MARK_PREFIX) begin
                        n.st = S_HUNT;
                    end
                end
                S_LEN: begin
                    n.len  = len_full;
                    n.bcnt = r.bcnt + 2'd1;
                    if (r.bcnt == 2'd3) begin
                        if (len_full < MIN_LEN) begin
                            set[ERR_LEN] = 1'b1;
                            n.st = S_HUNT;
                        end else if (len_full <= LEN_BYTES) begin
                            n.st = S_HUNT;
                        end else begin
                            n.rem = len_full - LEN_BYTES;
                            n.st = r.is_coll ? S_IDX : S_STYLE;
                        end
                    end
                end
                S_STYLE: begin
                    n.style_out.valid = 1'b1;
                    n.style_out.idx = in_data[STY_IDX_LSB +: 4];
                    n.style_out.mtype =
                        ccsp_mtype_t'(in_data[STY_TYPE_LSB +: 2]);
                    n.style_out.fmt =
                        ccsp_efmt_t'(in_data[STY_FMT_LSB +: 2]);
                    if (in_data[STY_IDX_LSB +: 4] == 4'h0) begin
                        set[ERR_STYLE] = 1'b1;
                    end else if (in_tile_hdr) begin
                        n.tile_mdef[in_data[5:0]] = 1'b1;
                    end
                    n.st = last ? S_HUNT : S_SKIP;
                end
                S_SKIP: begin
                    if (last) begin
                        n.st = S_HUNT;
                    end
                end
                S_IDX: begin
                    n.seg_idx = in_data;
                    n.tile = in_tile_hdr;
                    n.q    = 16'h0000;
                    n.seen = '0;
                    if (in_tile_hdr) begin
                        if (n.tile_seen) begin
                            set[ERR_TILE2] = 1'b1;
                        end
                        n.tile_seen = 1'b1;
                    end
                    if (in_tile_hdr && in_data != 8'h00 && !last) begin
                        set[ERR_EXTRA] = 1'b1;
                        n.st = S_SKIP;
                    end else if (last) begin
                        fin = 1'b1;
                        n.st = S_HUNT;
                    end else begin
                        n.st = S_KIND;
                    end
                end
                S_KIND: begin
                    n.coll_out = '0;
                    n.coll_out.wave = in_data[KIND_WAVE_BIT];
                    n.coll_out.hp_first =
                        in_data[KIND_WAVE_BIT] & in_data[KIND_HP_BIT];
                    n.bcnt = 2'd0;
                    n.st = S_NIN;
                end
                S_NIN, S_NOUT: begin
                    n.hi   = in_data;
                    n.bcnt = r.bcnt + 2'd1;
                    if (r.bcnt[0]) begin
                        n.bcnt = 2'd0;
                        n.cnt  = fld[IDX_BITS-1:0];
                        n.w16  = cnt_w16(fld);
                        if (fld[CNT_RSV_BIT]) begin
                            set[ERR_RANGE] = 1'b1;
                        end
                        if (r.st == S_NIN) begin
                            n.coll_out.n_in   = fld[IDX_BITS-1:0];
                            n.coll_out.in_w16 = cnt_w16(fld);
                            n.st = (fld[IDX_BITS-1:0] == 14'h0000) ?
                                   S_NOUT : S_CIN;
                        end else begin
                            n.coll_out.n_out   = fld[IDX_BITS-1:0];
                            n.coll_out.out_w16 = cnt_w16(fld);
                            if (r.coll_out.wave &&
                                fld[IDX_BITS-1:0] != r.coll_out.n_in) begin
                                set[ERR_WEQ] = 1'b1;
                            end
                            n.st = (fld[IDX_BITS-1:0] == 14'h0000) ?
                                   S_ASG : S_COUT;
                        end
                    end
                end
                S_CIN, S_COUT: begin
                    n.hi   = in_data;
                    n.bcnt = r.bcnt + 2'd1;
                    if (idx_done) begin
                        n.bcnt = 2'd0;
                        n.cnt  = r.cnt - 14'h0001;
                        // Emitted in stream order, which fixes the ordering
                        n.comp_out.valid  = 1'b1;
                        n.comp_out.is_out = (r.st == S_COUT);
                        n.comp_out.idx    = ix;
                        if (r.w16 && fld[15:14] != 2'b00) begin
                            set[ERR_RANGE] = 1'b1;
                        end
                        if (r.st == S_COUT) begin
                            if (r.seen[ix]) begin
                                set[ERR_DUP] = 1'b1;
                            end
                            n.seen[ix] = 1'b1;
                        end
                        if (r.cnt == 14'h0001) begin
                            n.st = (r.st == S_CIN) ? S_NOUT : S_ASG;
                        end
                    end
                end
                S_ASG: begin
                    // Same nibbles name kernel and decomposition for wavelets
                    n.coll_out.valid = 1'b1;
                    n.coll_out.t_idx = in_data[ASG_T_LSB +: 4];
                    n.coll_out.o_idx = in_data[ASG_O_LSB +: 4];
                    n.coll_out.t_tile = !r.coll_out.wave &&
                        r.tile_mdef[{MT_DECOR_XFORM, in_data[3:0]}];
                    n.coll_out.o_tile = !r.coll_out.wave &&
                        r.tile_mdef[{MT_DECOR_OFS, in_data[7:4]}];
                    n.q = r.q + 16'h0001;
                    fin = last;
                    n.st = last ? S_HUNT : S_KIND;
                end
                default: n.st = S_HUNT;
            endcase
            // A segment that runs out inside a collection is malformed
            if (last && mid) begin
                set[ERR_SIZE] = 1'b1;
                n.st = S_HUNT;
            end
        end

        if (fin) begin
            n.seg_out.valid     = 1'b1;
            n.seg_out.tile      = n.tile;
            n.seg_out.idx       = n.seg_idx;
            n.seg_out.apply_idx = n.seg_idx;
            n.seg_out.q         = n.q;
            n.seg_out.own = !n.tile || n.seg_idx == 8'h00;
            n.seg_out.ref_ok = n.seg_out.own || r.main_map[n.seg_idx];
            if (!n.seg_out.ref_ok) begin
                set[ERR_REF] = 1'b1;
            end
            if (!n.tile) begin
                n.main_map[n.seg_idx] = 1'b1;
            end
        end

        n.err = (r.err & ~clr) | set;
        n.in_ready = n.ctrl[CTRL_EN_BIT];
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            r      <= '0;
            r.st   <= S_HUNT;
            r.ctrl <= CTRL_RESET;
        end else begin
            r <= n;
        end
    end

    assign in_ready  = r.in_ready;
    assign style_out = r.style_out;
    assign coll_out  = r.coll_out;
    assign comp_out  = r.comp_out;
    assign seg_out   = r.seg_out;
    assign prdata    = r.prdata;
    assign pready    = r.pready;
    assign pslverr   = r.pslverr;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_style_idx;
        take && r.st == S_STYLE |=>
            style_out.valid && style_out.idx == $past(in_data[3:0]);
    endproperty
    a_style_idx: assert property (p_style_idx)
        else $error("style index not decoded");

    property p_style_type;
        take && r.st == S_STYLE |=> style_out.mtype == $past(in_data[5:4]);
    endproperty
    a_style_type: assert property (p_style_type)
        else $error("matrix type not decoded");

    property p_style_fmt;
        take && r.st == S_STYLE |=> style_out.fmt == $past(in_data[7:6]);
    endproperty
    a_style_fmt: assert property (p_style_fmt)
        else $error("element format not decoded");

    property p_marker;
        take && r.st == S_MARK && in_data == COLL_MARKER[7:0] |=>
            r.st == S_LEN && r.is_coll;
    endproperty
    a_marker: assert property (p_marker)
        else $error("collection marker missed");

    property p_len_min;
        take && r.st == S_LEN && r.bcnt == 2'd3 && len_full < MIN_LEN
            |=> r.err[ERR_LEN] && r.st == S_HUNT;
    endproperty
    a_len_min: assert property (p_len_min)
        else $error("short length not flagged");

    property p_size;
        take && last && mid |=> r.err[ERR_SIZE] && r.st == S_HUNT;
    endproperty
    a_size: assert property (p_size)
        else $error("length mismatch not flagged");

    property p_extra;
        take && r.st == S_IDX && in_tile_hdr && in_data != 8'h00 && !last
            |=> r.err[ERR_EXTRA] && r.st == S_SKIP;
    endproperty
    a_extra: assert property (p_extra)
        else $error("extra tile parameters not flagged");

    property p_tile2;
        take && r.st == S_IDX && in_tile_hdr && r.tile_seen && !tile_start
            |=> r.err[ERR_TILE2];
    endproperty
    a_tile2: assert property (p_tile2)
        else $error("second tile segment not flagged");

    property p_wave_eq;
        coll_out.valid && coll_out.wave && coll_out.n_in != coll_out.n_out
            |-> r.err[ERR_WEQ];
    endproperty
    a_wave_eq: assert property (p_wave_eq)
        else $error("unequal wavelet counts not flagged");

    property p_dup;
        take && r.st == S_COUT && idx_done && r.seen[ix] |=> r.err[ERR_DUP];
    endproperty
    a_dup: assert property (p_dup)
        else $error("duplicate output index not flagged");

    property p_apb_wait;
        acc && !pready |=> pready ##1 !pready;
    endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("APB answer not after one wait state");

    c_wave: cover property (coll_out.valid && coll_out.wave);
    c_tile_ref: cover property (seg_out.valid && seg_out.tile &&
                                !seg_out.own);
    c_style: cover property (style_out.valid && $past(in_tile_hdr));
    c_dup: cover property (r.err[ERR_DUP]);
endmodule // ccsp_parser

`default_nettype wire

// ==== verification/ccsp_byte_src.sv ====
// Purpose: Upstream codestream byte source model
// Assumes: The bench queues whole segments, well-formed or not, through push
// Notes:   Idle data toggles so a stale byte is never mistaken for new
`timescale 1ns/100ps
`default_nettype none
module ccsp_byte_src (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       in_ready,
    output logic            in_valid,
    output logic [7:0]      in_data
);
    logic [7:0] q[$];
    initial begin
        in_valid = 1'b0;
        in_data  = 8'h00;
    end
    task push(input logic [7:0] b);
        q.push_back(b);
    endtask
    // Byte stays put until the edge that takes it
    always @(posedge clk_sys) begin
        if (!rst && in_valid && in_ready)
            void'(q.pop_front());
        if (rst || q.size() == 0) begin
            in_valid <= 1'b0;
            in_data  <= ~in_data;
        end else begin
            in_valid <= 1'b1;
            in_data  <= q[0];
        end
    end
endmodule // ccsp_byte_src
`default_nettype wire

// ==== verification/ccsp_parser_tb.sv ====
// Purpose: Self-checking bench of the segment parser
// Assumes: Events pulse one cycle after the byte that ends them
// Notes:   Pulsed outputs are latched so tasks judge them afterwards
`timescale 1ns/100ps
`default_nettype none
module ccsp_parser_tb;
    import ccsp_pkg::*;
    logic        clk_sys = 0, rst = 1, in_tile_hdr = 0, tile_start = 0;
    logic        in_valid, in_ready, psel = 0, penable = 0, pwrite = 0;
    logic        pready, pslverr, slv;
    logic [7:0]  in_data;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [14:0] comp_q[$];
    ccsp_style_t style_out, sty_q;
    ccsp_coll_t  coll_out, coll_q;
    ccsp_comp_t  comp_out;
    ccsp_seg_t   seg_out, seg_q;
    int          err_count = 0, checks_done = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    ccsp_byte_src i_src (.clk_sys(clk_sys), .rst(rst), .in_ready(in_ready),
        .in_valid(in_valid), .in_data(in_data));
    ccsp_parser i_dut (.clk_sys(clk_sys), .rst(rst), .in_valid(in_valid),
        .in_data(in_data), .in_ready(in_ready), .in_tile_hdr(in_tile_hdr),
        .tile_start(tile_start), .style_out(style_out), .coll_out(coll_out),
        .comp_out(comp_out), .seg_out(seg_out), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr));
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (style_out.valid === 1'b1) sty_q <= style_out;
        if (coll_out.valid === 1'b1) coll_q <= coll_out;
        if (seg_out.valid === 1'b1) seg_q <= seg_out;
        if (comp_out.valid === 1'b1) comp_q.push_back(comp_out[14:0]);
        if (cyc == 20000) begin
            err_count++;
            print_verdict();
        end
    end
    task print_verdict;
        $display("errors %0d checks %0d", err_count, checks_done);
        if (err_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_sys);
        end
        if (n >= 50) err_count++;
        rd = prdata;
        slv = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task send(input logic [7:0] b[$]);
        int n;
        foreach (b[i]) i_src.push(b[i]);
        n = 0;
        while (i_src.q.size() != 0 && n < 500) begin
            n++;
            @(posedge clk_sys);
        end
        if (n >= 500) err_count++;
        repeat (3) @(posedge clk_sys);
    endtask
    task t_apb;
        apb(1'b0, 12'h010, 32'h0);
        chk({slv, rd}, {1'b1, 32'h0});
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rd, CTRL_RESET);
    endtask
    task t_main(input logic [7:0] k);
        comp_q.delete();
        send('{8'hFF, 8'h75, 8'h00, 8'h00, 8'h00, 8'h0D, 8'h00, k, 8'h00,
            8'h01, 8'h05, 8'h00, 8'h01, 8'h07, 8'h21});
        chk(comp_q[0], {1'b0, 14'h0005});
        chk(comp_q[1], {1'b1, 14'h0007});
        chk({coll_q.wave, coll_q.hp_first}, {k[1], k[1] & k[0]});
        chk({coll_q.n_in, coll_q.in_w16, coll_q.n_out, coll_q.out_w16},
            {14'h0001, 1'b0, 14'h0001, 1'b0});
        chk({coll_q.t_idx, coll_q.o_idx}, 8'h12);
        chk({seg_q.tile, seg_q.own, seg_q.ref_ok, seg_q.idx, seg_q.q},
            {3'b011, 8'h00, 16'h0001});
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd, 32'h0001_0000);
    endtask
    task t_style;
        logic [7:0] s;
        for (int i = 0; i < 4; i++) begin
            s = {2'(i), 2'(3 - i), 4'(i + 1)};
            send('{8'hFF, 8'h74, 8'h00, 8'h00, 8'h00, 8'h05, s});
            chk(sty_q[7:0], s);
            apb(1'b0, REG_STYLE, 32'h0);
            chk(rd, {24'h0, s});
        end
    endtask
    task t_len;
        send('{8'hFF, 8'h75, 8'h00, 8'h00, 8'h00, 8'h02});
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd[0], 1'b1);
        apb(1'b1, REG_STATUS, 32'h0000_01FF);
    endtask
    task t_tile;
        in_tile_hdr <= 1'b1;
        send('{8'hFF, 8'h75, 8'h00, 8'h00, 8'h00, 8'h05, 8'h03});
        chk({seg_q.tile, seg_q.own, seg_q.ref_ok, seg_q.apply_idx},
            {3'b100, 8'h03});
        send('{8'hFF, 8'h75, 8'h00, 8'h00, 8'h00, 8'h05, 8'h03});
        apb(1'b0, REG_STATUS, 32'h0);
        chk({rd[8], rd[3]}, 2'b11);
        in_tile_hdr <= 1'b0;
        tile_start <= 1'b1;
        @(posedge clk_sys);
        tile_start <= 1'b0;
    endtask
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_apb();
        t_main(8'h00);
        t_main(8'h03);
        t_style();
        t_len();
        t_tile();
        print_verdict();
    end
endmodule // ccsp_parser_tb
`default_nettype wire
